// [sph_pkg.sv]
// Notes on behaviour
// R1 - Transfer select 00 uses command registers, 11 buffer port, 10 reserved.
// R2 - Transfer select 01 acts as 11 but keeps whole frames aligned.
// R3 - Host must pick transfer select 11 for DMA playback transfers.
// R4 - Host should pick poll-synchronised playback with buffer port transfers.
// R5 - With 11 or 01 second and third pairs happen once at start.
// R6 - Data transfer command echoes a speech word; transfer select 00 only.
// R7 - Second status: 0001, tone flags, 00, keypad valid, call valid, digit.
// R8 - Third command: 0010, zeros, requested words per frame in low byte.
// R9 - Third status: 0010, zeros, actual words per frame in low byte.
// R10 - Format 000 compressed, 010/100/101 120 words, 110 240, rest reserved.
// R11 - Frame interval of 30 ms counts 240 codec samples at 8000 per second.
// R12 - Companded format passes host data unmodified when volume equals 0100H.
// R13 - Sixteen-bit samples are two's complement, 7FFFH top, 8000H bottom.
// R14 - Unsigned bytes convert to signed bytes by inverting the top bit.
// R15 - Host starts playback only from idle or record after control ready.
// R16 - Each command posts a response and status ready; reading clears it.
// R17 - Host sends rate, poll sync, then three play commands; echoes checked.
// R18 - One frame consumed per frame interval; host writes a frame per ready.
// R19 - 240 words of buffering; ready repeats until full; 528XH lowers depth.
// R20 - Idle or stop ends play, flushes buffer, drops ready, then responds; with select 00 the code takes idle as a data word.
// R21 - Buffer monitoring command 5212H reports buffered speech remaining.
// R22 - After idle or stop the host leaves the buffer port alone.
// R23 - First command holds 0010, 11, 000, format, 00, transfer select.
// R24 - Buffer port words play out in order; ready drops at configured depth.
package sph_pkg;

  // Register byte addresses
  localparam logic [7:0]  ADDR_CMD    = 8'h00;
  localparam logic [7:0]  ADDR_STATUS = 8'h04;
  localparam logic [7:0]  ADDR_HWSTAT = 8'h08;
  localparam logic [7:0]  ADDR_TXDATA = 8'h0C;
  localparam logic [7:0]  ADDR_VOLUME = 8'h10;

  // Hardware status bit positions
  localparam int HW_CTRL_READY = 0;
  localparam int HW_STAT_READY = 1;
  localparam int HW_TX_READY   = 2;
  localparam int HW_PLAYING    = 3;
  localparam int HW_BUF_EMPTY  = 4;
  localparam int HW_POLL_SYNC  = 5;

  // Command words
  localparam logic [15:0] CMD_IDLE       = 16'h0000;
  localparam logic [15:0] CMD_STOP       = 16'h5220;
  localparam logic [15:0] CMD_MONITOR    = 16'h5212;
  localparam logic [15:0] CMD_POLL_SYNC  = 16'h5202;
  localparam logic [11:0] CMD_RATE_PFX   = 12'h523;
  localparam logic [11:0] CMD_DEPTH_PFX  = 12'h528;
  localparam logic [3:0]  PLAY_GROUP     = 4'h2;
  localparam logic [1:0]  C1_TAG         = 2'b11;
  localparam logic [3:0]  S2_TAG         = 4'h1;
  localparam logic [7:0]  MON_TAG        = 8'h52;
  localparam logic [15:0] RESP_ERROR     = 16'hFFFF;

  // Transfer select codes
  localparam logic [1:0] TFR_REGS   = 2'b00;
  localparam logic [1:0] TFR_STRICT = 2'b01;
  localparam logic [1:0] TFR_RSVD   = 2'b10;
  localparam logic [1:0] TFR_PORT   = 2'b11;

  // Playback formats
  localparam logic [2:0] FMT_COMP = 3'b000;
  localparam logic [2:0] FMT_PCM  = 3'b010;
  localparam logic [2:0] FMT_S8   = 3'b100;
  localparam logic [2:0] FMT_U8   = 3'b101;
  localparam logic [2:0] FMT_S16  = 3'b110;

  // Frame sizes in words
  localparam logic [7:0] WORDS_BYTE = 8'd120;
  localparam logic [7:0] WORDS_S16  = 8'd240;
  localparam logic [7:0] WORDS_MIN  = 8'd8;
  localparam logic [7:0] WORDS_MAX  = 8'd16;

  // Buffer and volume
  localparam int          BUF_WORDS    = 240;
  localparam logic [7:0]  DEPTH_RESET  = 8'd240;
  localparam logic [15:0] VOLUME_UNITY = 16'h0100;
  localparam logic [15:0] BYTE_SIGN    = 16'h8080;

  // Frame timing, counted in codec samples
  localparam int FRAME_MS          = 30;
  localparam int SAMPLE_RATE_HZ    = 8000;
  localparam int SAMPLES_PER_FRAME = SAMPLE_RATE_HZ * FRAME_MS / 1000;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_WAIT_C2 = 2'b01,
    ST_WAIT_C3 = 2'b11,
    ST_PLAYING = 2'b10
  } sph_state_t;

  function automatic logic fmt_ok(input logic [2:0] fmt);
    fmt_ok = (fmt == FMT_COMP) || (fmt == FMT_PCM) || (fmt == FMT_S8) ||
             (fmt == FMT_U8) || (fmt == FMT_S16);
  endfunction : fmt_ok

  function automatic logic [7:0] frame_words(input logic [2:0] fmt,
                                             input logic [7:0] req);
    if (fmt == FMT_S16) begin
      frame_words = WORDS_S16;
    end else if (fmt != FMT_COMP) begin
      frame_words = WORDS_BYTE;
    end else if (req < WORDS_MIN) begin
      frame_words = WORDS_MIN;
    end else if (req > WORDS_MAX) begin
      frame_words = WORDS_MAX;
    end else begin
      frame_words = req;
    end
  endfunction : frame_words

endpackage : sph_pkg

// [sph_word_fifo.sv]
`timescale 1ns/100ps
`default_nettype none
module sph_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 240,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] data_i,
  // Drain side
  input  wire logic             pop_i,
  input  wire logic             flush_i,
  output logic      [WIDTH-1:0] head_o,
  output logic      [LW-1:0]    level_o,
  output logic                  empty_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [LW-1:0]    level;

  function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
    wrap = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : wrap

  wire do_push = push_i && (level != LW'(DEPTH)) && !flush_i;
  wire do_pop  = pop_i && (level != '0) && !flush_i;

  assign head_o  = mem[rd_ptr];
  assign level_o = level;
  assign empty_o = (level == '0);

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= data_i;
    end
  end

  // Flush drops everything, including a word offered in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else if (flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (do_push) wr_ptr <= wrap(wr_ptr);
      if (do_pop) rd_ptr <= wrap(rd_ptr);
      level <= level + LW'(do_push) - LW'(do_pop);
    end
  end
endmodule : sph_word_fifo
`default_nettype wire

// [sph_frame_pacer.sv]
`timescale 1ns/100ps
`default_nettype none
module sph_frame_pacer #(
  parameter int SAMPLES = sph_pkg::SAMPLES_PER_FRAME
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic run_i,
  input  wire logic tick_i,
  // Frame boundary pulse
  output logic      frame_o
);
  localparam int CW = $clog2(SAMPLES);

  logic [CW-1:0] count;

  wire last = (count == CW'(SAMPLES - 1));

  // R11 frame sample count
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count   <= '0;
      frame_o <= 1'b0;
    end else if (!run_i) begin
      count   <= '0;
      frame_o <= 1'b0;
    end else begin
      frame_o <= tick_i && last;
      if (tick_i) count <= last ? '0 : count + CW'(1);
    end
  end
endmodule : sph_frame_pacer
`default_nettype wire

// [sph_playback.sv]
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module sph_playback #(
  parameter int BUF_WORDS = sph_pkg::BUF_WORDS,
  parameter int SAMPLES   = sph_pkg::SAMPLES_PER_FRAME
) (
  // Clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESETN_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Transmit DMA
  output logic             TX_DMA_REQUEST_O,
  input  wire logic        TX_DMA_ACK_N_I,
  input  wire logic [15:0] TX_DMA_DATA_I,
  // Line monitor results
  input  wire logic [3:0]  TONE_FLAGS_I,
  input  wire logic        KEYPAD_TONE_VALID_I,
  input  wire logic        CALL_PROGRESS_VALID_I,
  input  wire logic [3:0]  KEYPAD_TONE_DIGIT_I,
  // Codec side
  input  wire logic        SAMPLE_TICK_I,
  output logic      [15:0] CODEC_DATA_O,
  output logic             CODEC_VALID_O,
  output logic             FRAME_START_O
);
  localparam int LW = $clog2(BUF_WORDS + 1);

  // Reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // State
  sph_pkg::sph_state_t state;
  sph_pkg::sph_state_t next_state;
  logic [15:0] cmd_word;
  logic        cmd_pending;
  logic [15:0] status_word;
  logic        status_ready;
  logic [1:0]  transfer_select;
  logic [2:0]  playback_format;
  logic [7:0]  words_per_frame;
  logic [7:0]  depth;
  logic        poll_sync;
  logic [15:0] volume;
  logic        tx_ready;
  logic [7:0]  drain_cnt;
  logic        pready;

  // Buffer wiring
  logic          fifo_push;
  logic [15:0]   fifo_din;
  logic          fifo_pop;
  logic          fifo_flush;
  logic [15:0]   fifo_head;
  logic [LW-1:0] fifo_level;
  logic          fifo_empty;
  logic          frame_pulse;

  // Command interpreter outputs
  logic [15:0] next_resp;
  logic        next_flush;
  logic        next_cmd_push;
  logic        next_latch_c1;
  logic        next_latch_c3;
  logic        next_set_depth;
  logic        next_set_poll;

  // APB decode
  wire apb_access = PSEL_I && PENABLE_I;
  wire apb_done   = apb_access && pready;
  wire hit_cmd    = (PADDR_I == sph_pkg::ADDR_CMD);
  wire hit_status = (PADDR_I == sph_pkg::ADDR_STATUS);
  wire hit_hwstat = (PADDR_I == sph_pkg::ADDR_HWSTAT);
  wire hit_txdata = (PADDR_I == sph_pkg::ADDR_TXDATA);
  wire hit_volume = (PADDR_I == sph_pkg::ADDR_VOLUME);
  wire addr_hit   = hit_cmd || hit_status || hit_hwstat || hit_txdata ||
                    hit_volume;

  wire playing    = (state == sph_pkg::ST_PLAYING);
  wire port_mode  = (transfer_select != sph_pkg::TFR_REGS);
  wire strict     = (transfer_select == sph_pkg::TFR_STRICT);

  wire wr_cmd     = apb_done && PWRITE_I && hit_cmd;
  wire wr_volume  = apb_done && PWRITE_I && hit_volume;
  // R16 read clears ready
  wire rd_status  = apb_done && !PWRITE_I && hit_status;
  // R22 port closed outside play
  wire wr_tx      = apb_done && PWRITE_I && hit_txdata && playing &&
                    port_mode;
  // R3 DMA only in port mode
  wire dma_push   = !TX_DMA_ACK_N_I && TX_DMA_REQUEST_O && playing &&
                    port_mode && !wr_tx;

  wire [15:0] hw_status = {10'h000,
                           poll_sync,
                           fifo_empty,
                           playing,
                           tx_ready,
                           status_ready,
                           !cmd_pending};

  wire [15:0] rd_mux = hit_cmd    ? cmd_word    :
                       hit_status ? status_word :
                       hit_hwstat ? hw_status   :
                       hit_volume ? volume      : 16'h0000;

  // Command field decode
  wire is_idle  = (cmd_word == sph_pkg::CMD_IDLE);
  wire is_stop  = (cmd_word == sph_pkg::CMD_STOP);
  wire is_end   = is_idle || is_stop;
  wire is_mon   = (cmd_word == sph_pkg::CMD_MONITOR);
  wire is_poll  = (cmd_word == sph_pkg::CMD_POLL_SYNC);
  wire is_rate  = (cmd_word[15:4] == sph_pkg::CMD_RATE_PFX);
  wire is_depth = (cmd_word[15:4] == sph_pkg::CMD_DEPTH_PFX);
  wire is_play  = (cmd_word[15:12] == sph_pkg::PLAY_GROUP);

  // R23 first command layout
  // R1 reserved select refused
  wire c1_ok = is_play && (cmd_word[11:10] == sph_pkg::C1_TAG) &&
               (cmd_word[9:7] == 3'b000) && (cmd_word[3:2] == 2'b00) &&
               sph_pkg::fmt_ok(cmd_word[6:4]) &&
               (cmd_word[1:0] != sph_pkg::TFR_RSVD);
  // R8 third command layout
  wire c3_ok = is_play && (cmd_word[11:8] == 4'h0);

  // R7 second status layout
  wire [15:0] s2_word = {sph_pkg::S2_TAG, TONE_FLAGS_I, 2'b00,
                         KEYPAD_TONE_VALID_I, CALL_PROGRESS_VALID_I,
                         KEYPAD_TONE_DIGIT_I};
  wire [7:0]  actual_words = sph_pkg::frame_words(playback_format,
                                                  cmd_word[7:0]);
  // R9 third status layout
  wire [15:0] s3_word = {sph_pkg::PLAY_GROUP, 4'h0, actual_words};
  // R21 buffered words report
  wire [15:0] mon_word = {sph_pkg::MON_TAG, 8'(fifo_level)};
  // R19 depth in steps of 16
  wire [7:0]  new_depth = (cmd_word[3:0] == 4'h0) ? sph_pkg::DEPTH_RESET :
                          {cmd_word[3:0], 4'h0};

  always_comb begin
    next_state     = state;
    next_resp      = sph_pkg::RESP_ERROR;
    next_flush     = 1'b0;
    next_cmd_push  = 1'b0;
    next_latch_c1  = 1'b0;
    next_latch_c3  = 1'b0;
    next_set_depth = 1'b0;
    next_set_poll  = 1'b0;
    if (cmd_pending) begin
      unique case (state)
        sph_pkg::ST_IDLE: begin
          if (c1_ok) begin
            next_resp     = cmd_word;
            next_latch_c1 = 1'b1;
            next_flush    = 1'b1;
            next_state    = sph_pkg::ST_WAIT_C2;
          end else if (is_end || is_rate || is_mon) begin
            next_resp = is_mon ? mon_word : cmd_word;
          end else if (is_poll) begin
            next_resp     = cmd_word;
            next_set_poll = 1'b1;
          end else if (is_depth) begin
            next_resp      = cmd_word;
            next_set_depth = 1'b1;
          end
        end
        sph_pkg::ST_WAIT_C2: begin
          if (is_end) begin
            next_resp  = cmd_word;
            next_state = sph_pkg::ST_IDLE;
          end else if (is_play) begin
            next_resp  = s2_word;
            next_state = sph_pkg::ST_WAIT_C3;
          end
        end
        sph_pkg::ST_WAIT_C3: begin
          if (is_end) begin
            next_resp  = cmd_word;
            next_state = sph_pkg::ST_IDLE;
          end else if (c3_ok) begin
            // R5 setup pairs end here
            next_resp     = s3_word;
            next_latch_c3 = 1'b1;
            next_state    = sph_pkg::ST_PLAYING;
          end
        end
        sph_pkg::ST_PLAYING: begin
          if (is_stop || (port_mode && is_idle)) begin
            // R20 stop and discard
            next_resp  = cmd_word;
            next_flush = 1'b1;
            next_state = sph_pkg::ST_IDLE;
          end else if (!port_mode) begin
            // R6 data word echoed
            next_resp     = cmd_word;
            next_cmd_push = 1'b1;
          end else if (is_mon) begin
            next_resp = mon_word;
          end else if (is_depth) begin
            next_resp      = cmd_word;
            next_set_depth = 1'b1;
          end
        end
      endcase
    end
  end

  // R24 in-order buffer fill
  assign fifo_push  = wr_tx || dma_push || next_cmd_push;
  assign fifo_din   = wr_tx         ? PWDATA_I[15:0] :
                      next_cmd_push ? cmd_word       : TX_DMA_DATA_I;
  assign fifo_flush = next_flush;
  assign fifo_pop   = (drain_cnt != 8'h00) && !fifo_empty && !next_flush;

  wire [LW:0] next_fill = {1'b0, fifo_level} + (LW+1)'(fifo_push) -
                          (LW+1)'(fifo_pop);
  // R19 ready until depth reached
  wire next_tx_ready = (next_state == sph_pkg::ST_PLAYING) && port_mode &&
                       !next_flush && (next_fill < (LW+1)'(depth));

  // R2 strict frames wait whole
  wire frame_short  = strict && (fifo_level < LW'(words_per_frame));
  wire [7:0] next_drain = next_flush ? 8'h00 :
                          (frame_pulse && playing) ?
                            (frame_short ? 8'h00 : words_per_frame) :
                          fifo_pop ? drain_cnt - 8'h01 :
                          fifo_empty ? 8'h00 : drain_cnt;

  // R13 16-bit gain path
  wire signed [31:0] gain_prod = $signed(fifo_head) * $signed(volume);
  wire [15:0] gained = gain_prod[23:8];
  wire unity = (volume == sph_pkg::VOLUME_UNITY);
  // R12 companded pass-through
  // R14 unsigned bytes made signed
  wire [15:0] shaped =
    (playback_format == sph_pkg::FMT_U8)  ? fifo_head ^ sph_pkg::BYTE_SIGN :
    ((playback_format == sph_pkg::FMT_S16) ||
     (playback_format == sph_pkg::FMT_PCM)) && !unity ? gained :
    fifo_head;

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      pready    <= 1'b0;
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      pready    <= apb_access && !pready;
      PREADY_O  <= apb_access && !pready;
      PSLVERR_O <= apb_access && !pready && !addr_hit;
      if (apb_access && !pready && !PWRITE_I) PRDATA_O <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      cmd_word    <= sph_pkg::CMD_IDLE;
      cmd_pending <= 1'b0;
      volume      <= sph_pkg::VOLUME_UNITY;
    end else begin
      cmd_pending <= wr_cmd;
      if (wr_cmd) cmd_word <= PWDATA_I[15:0];
      if (wr_volume) volume <= PWDATA_I[15:0];
    end
  end

  // R16 response posts status ready
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      status_word  <= 16'h0000;
      status_ready <= 1'b0;
    end else begin
      if (cmd_pending) status_word <= next_resp;
      status_ready <= cmd_pending || (status_ready && !rd_status);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      state           <= sph_pkg::ST_IDLE;
      transfer_select <= sph_pkg::TFR_REGS;
      playback_format <= sph_pkg::FMT_COMP;
      words_per_frame <= sph_pkg::WORDS_MIN;
      depth           <= sph_pkg::DEPTH_RESET;
      poll_sync       <= 1'b0;
    end else begin
      state <= next_state;
      if (next_latch_c1) begin
        transfer_select <= cmd_word[1:0];
        playback_format <= cmd_word[6:4];
      end
      // R10 frame size by format
      if (next_latch_c3) words_per_frame <= actual_words;
      if (next_set_depth) depth <= new_depth;
      if (next_set_poll) poll_sync <= 1'b1;
    end
  end

  // R18 one frame per interval
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      drain_cnt        <= 8'h00;
      tx_ready         <= 1'b0;
      TX_DMA_REQUEST_O <= 1'b0;
      CODEC_DATA_O     <= 16'h0000;
      CODEC_VALID_O    <= 1'b0;
      FRAME_START_O    <= 1'b0;
    end else begin
      drain_cnt        <= next_drain;
      tx_ready         <= next_tx_ready;
      TX_DMA_REQUEST_O <= next_tx_ready;
      CODEC_VALID_O    <= fifo_pop;
      FRAME_START_O    <= frame_pulse && playing;
      if (fifo_pop) CODEC_DATA_O <= shaped;
    end
  end

  sph_word_fifo #(
    .WIDTH (16),
    .DEPTH (BUF_WORDS),
    .LW    (LW)
  ) u_fifo (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (rst_n),
    .push_i  (fifo_push),
    .data_i  (fifo_din),
    .pop_i   (fifo_pop),
    .flush_i (fifo_flush),
    .head_o  (fifo_head),
    .level_o (fifo_level),
    .empty_o (fifo_empty)
  );

  sph_frame_pacer #(
    .SAMPLES (SAMPLES)
  ) u_pacer (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (rst_n),
    .run_i   (playing),
    .tick_i  (SAMPLE_TICK_I),
    .frame_o (frame_pulse)
  );
endmodule : sph_playback
`default_nettype wire

// [sph_playback_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module sph_playback_asserts #(
  parameter int SAMPLES = 240
) (
  // Clock, reset and bus
  input wire logic       CLK_SYS_I,
  input wire logic       RESETN_I,
  input wire logic       PSEL_I,
  input wire logic       PENABLE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic       PREADY_O,
  input wire logic       PSLVERR_O,
  // Stream side
  input wire logic       TX_DMA_REQUEST_O,
  input wire logic       SAMPLE_TICK_I,
  input wire logic       CODEC_VALID_O,
  input wire logic       FRAME_START_O
);
  logic [15:0] ticks;

  // Ticks seen since the last frame pulse, saturating
  always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ticks <= 16'(SAMPLES);
    end else if (FRAME_START_O) begin
      ticks <= 16'h0000;
    end else if (SAMPLE_TICK_I && ticks != 16'hFFFF) begin
      ticks <= ticks + 16'h0001;
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  sequence setup_s;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence one_wait_s;
    PSEL_I && PENABLE_I && !PREADY_O ##1 PREADY_O;
  endsequence

  ready_timing_a: assert property (setup_s |=> one_wait_s)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  ready_access_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("ready outside access phase");
  err_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  err_map_a: assert property (PREADY_O |-> PSLVERR_O ==
    (PADDR_I > 8'h10 || PADDR_I[1:0] != 2'h0))
    else $error("error flag disagrees with map");
  frame_pulse_a: assert property (FRAME_START_O |=> !FRAME_START_O)
    else $error("frame pulse too long");
  frame_gap_a: assert property (FRAME_START_O |-> ticks >= 16'(SAMPLES))
    else $error("frame before sample count");
  reset_quiet_a: assert property ($rose(RESETN_I) |-> !PREADY_O &&
    !TX_DMA_REQUEST_O && !CODEC_VALID_O && !FRAME_START_O)
    else $error("outputs active after reset");
endmodule : sph_playback_asserts

bind sph_playback sph_playback_asserts #(.SAMPLES(SAMPLES)) i_asserts (
  .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .TX_DMA_REQUEST_O(TX_DMA_REQUEST_O),
  .SAMPLE_TICK_I(SAMPLE_TICK_I), .CODEC_VALID_O(CODEC_VALID_O),
  .FRAME_START_O(FRAME_START_O));
`default_nettype wire

// [sph_dma_model.sv]
`timescale 1ns/100ps
`default_nettype none
module sph_dma_model (
  // Clock and control
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic        slow_i,
  // Device handshake
  input  wire logic        req_i,
  output logic             ack_n_o,
  output logic      [15:0] data_o
);
  logic [15:0] count;
  logic        phase;

  // words go out only while the device asks
  assign ack_n_o = !(run_i && req_i && (phase || !slow_i));
  // Bus not valid outside an acknowledge shows the inverse
  assign data_o = ack_n_o ? ~count : count;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 16'h0100;
      phase <= 1'b0;
    end else begin
      phase <= !phase;
      if (!ack_n_o) begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule : sph_dma_model
`default_nettype wire

// [test_speech_playback_host_protocol.sv]
`timescale 1ns/100ps
`default_nettype none
module test_speech_playback_host_protocol;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, err, tick = 1'b0;
  logic        dma_req, dma_ack_n, codec_valid, frame_start;
  logic        run = 1'b0, slow = 1'b1, tick_en = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [2:0]  tick_div = 3'h0;
  logic [15:0] dma_data, codec_data, exp_word = 16'h0100;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int          mismatches = 0, check_count = 0, cycles = 0, fcount = 0, n;
  logic [31:0] rows [43] = '{
    32'h5231_5231, 32'h5202_5202, 32'h5283_5283, 32'h1234_FFFF,
    32'h2C13_FFFF, 32'h2C33_FFFF, 32'h2C73_FFFF, 32'h2C02_FFFF,
    32'h5220_5220, 32'h0000_0000,
    32'h2C03_2C03, 32'h2000_1A27, 32'h2014_2010, 32'h5212_5200,
    32'h0000_0000, 32'h2C01_2C01, 32'h2000_1A27, 32'h2003_2008,
    32'h5220_5220, 32'h2C23_2C23, 32'h2000_1A27, 32'h2005_2078,
    32'h5220_5220, 32'h2C43_2C43, 32'h2000_1A27, 32'h2001_2078,
    32'h5220_5220, 32'h2C53_2C53, 32'h2000_1A27, 32'h20FF_2078,
    32'h5220_5220, 32'h2C63_2C63, 32'h2000_1A27, 32'h20F0_20F0,
    32'h5220_5220, 32'h2C03_2C03, 32'h0000_0000,
    32'h2C00_2C00, 32'h2000_1A27, 32'h200C_200C, 32'h0000_0000,
    32'h7FFF_7FFF, 32'h5220_5220};

  sph_playback #(.SAMPLES(4)) i_dut (
    .CLK_SYS_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .TX_DMA_REQUEST_O(dma_req), .TX_DMA_ACK_N_I(dma_ack_n),
    .TX_DMA_DATA_I(dma_data), .TONE_FLAGS_I(4'hA),
    .KEYPAD_TONE_VALID_I(1'b1), .CALL_PROGRESS_VALID_I(1'b0),
    .KEYPAD_TONE_DIGIT_I(4'h7), .SAMPLE_TICK_I(tick),
    .CODEC_DATA_O(codec_data), .CODEC_VALID_O(codec_valid),
    .FRAME_START_O(frame_start));

  sph_dma_model i_dma (
    .clk_i(clk), .rst_n_i(rst_n), .run_i(run), .slow_i(slow),
    .req_i(dma_req), .ack_n_o(dma_ack_n), .data_o(dma_data));

  always #2.5 clk = ~clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic poll(input int bit_idx);
    rd = 32'h0;
    while (rd[bit_idx] !== 1'b1) apb(1'b0, sph_pkg::ADDR_HWSTAT, 16'h0000);
  endtask : poll

  task automatic cmd(input logic [15:0] c, input logic [15:0] e);
    // control ready seen before each command
    poll(sph_pkg::HW_CTRL_READY);
    apb(1'b1, sph_pkg::ADDR_CMD, c);
    poll(sph_pkg::HW_STAT_READY);
    apb(1'b0, sph_pkg::ADDR_STATUS, 16'h0000);
    check(rd, {16'h0000, e});
    apb(1'b0, sph_pkg::ADDR_HWSTAT, 16'h0000);
    check({31'h0, rd[sph_pkg::HW_STAT_READY]}, 32'h0);
  endtask : cmd

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
    tick_div <= tick_div + 3'h1;
    tick <= tick_en && tick_div == 3'h7;
    if (codec_valid === 1'b1) begin
      check({16'h0000, codec_data}, {16'h0000, exp_word});
      exp_word <= exp_word + 16'h0001;
      fcount <= fcount + 1;
    end
    if (frame_start === 1'b1) begin
      if (fcount != 0) check(fcount, 32'd12);
      fcount <= 0;
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, sph_pkg::ADDR_VOLUME, 16'h0000);
    check(rd, 32'h0000_0100);
    foreach (rows[i]) cmd(rows[i][31:16], rows[i][15:0]);
    apb(1'b0, 8'h14, 16'h0000);
    check({err, rd[30:0]}, 32'h8000_0000);
    $display("command table done");
    cmd(16'h5231, 16'h5231);
    cmd(16'h5202, 16'h5202);
    cmd(16'h2C03, 16'h2C03);
    cmd(16'h2000, 16'h1A27);
    cmd(16'h200C, 16'h200C);
    run <= 1'b1;
    // Codec stalled, so the buffer fills to the 48-word depth set by 5283
    for (n = 0; n < 900 && dma_req !== 1'b0; n++) @(posedge clk);
    cmd(16'h5212, 16'h5230);
    check({dma_req, rd[sph_pkg::HW_TX_READY]}, 32'h0);
    slow <= 1'b0;
    tick_en <= 1'b1;
    repeat (4) @(posedge frame_start);
    cmd(16'h5220, 16'h5220);
    check({dma_req, rd[sph_pkg::HW_BUF_EMPTY]}, 32'h1);
    // port left alone after the stop
    run <= 1'b0;
    $display("dma playback done");
    apb(1'b1, sph_pkg::ADDR_VOLUME, 16'h0200);
    apb(1'b0, sph_pkg::ADDR_VOLUME, 16'h0000);
    check(rd, 32'h0000_0200);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, sph_pkg::ADDR_VOLUME, 16'h0000);
    check(rd, 32'h0000_0100);
    $display("reset test done");
    close_out();
  end
endmodule : test_speech_playback_host_protocol
`default_nettype wire
